// ==== bench/hps_slot_model.sv ====
// Two hot plug slots with their on-board power controllers.
// Assumes the bench sets card codes and overloads between pclk edges.
`timescale 1ns/1ns
module hps_slot_model (
    input  wire logic       power1,   // Slot-1 power enable
    input  wire logic       power2,   // Slot-2 power enable
    input  wire logic [1:0] card1,    // Slot-1 card code {b,a}, 11 empty
    input  wire logic [1:0] card2,    // Slot-2 card code {b,a}, 11 empty
    input  wire logic       short1,   // Overload on slot 1
    input  wire logic       short2,   // Overload on slot 2
    input  wire logic [1:0] alt_irq,  // Alternate interrupts on fault pads {2,1}
    output logic            pa1_n,    // Slot-1 present pin a
    output logic            pb1_n,    // Slot-1 present pin b
    output logic            pa2_n,    // Slot-2 present pin a
    output logic            pb2_n,    // Slot-2 present pin b
    output logic            flt1_n,   // Slot-1 fault pin
    output logic            flt2_n    // Slot-2 fault pin
);
    assign pa1_n = card1[0];
    assign pb1_n = card1[1];
    assign pa2_n = card2[0];
    assign pb2_n = card2[1];
    // A controller reports overload only while it supplies power
    // A device sharing the pad may pull it low while the slot is not in hot plug use
    assign flt1_n = ~(short1 & power1) & ~alt_irq[0];
    assign flt2_n = ~(short2 & power2) & ~alt_irq[1];
endmodule // hps_slot_model

// ==== bench/test_hps_top.sv ====
// Self-checking bench of the hot plug slot signal block.
// Assumes APB with zero wait states; pins from the slot model.
`timescale 1ns/1ns
`include "hps_map.svh"
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_hps_top;
    import hps_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, err, power_good = 0, grant_n = 1;
    logic [3:0]  strap = 0;
    logic [1:0]  card1 = 3, card2 = 3, alt_irq = 0;
    logic        short1 = 0, short2 = 0, pa1, pb1, pa2, pb2, f1, f2;
    logic        pw1, pw2, l1, l2, r1, r2, g3, q4, i14, i13, irq;
    int          fails = 0, n_compared = 0;
    always #2 pclk = ~pclk;
    hps_top i_hps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_good(power_good), .hot_plug_mode_strap(strap),
        .slot1_presence_a_n(pa1), .slot1_presence_b_n(pb1), .slot2_presence_a_n(pa2),
        .slot2_presence_b_n(pb2), .slot1_power_fault_n(f1), .slot2_power_fault_n(f2),
        .arb_grant_3_in_n(grant_n), .slot1_power_on(pw1), .slot2_power_on(pw2),
        .slot1_power_lamp_n(l1), .slot2_power_lamp_n(l2), .slot1_reset_n(r1),
        .slot2_reset_n(r2), .bus_grant_3_n(g3), .bus_request_4_n(q4),
        .slot_interrupt_14_n(i14), .slot_interrupt_13_n(i13), .irq(irq));
    hps_slot_model i_hps_slot_model (.power1(pw1), .power2(pw2), .card1(card1),
        .card2(card2), .short1(short1), .short2(short2), .alt_irq(alt_irq),
        .pa1_n(pa1), .pb1_n(pb1),
        .pa2_n(pa2), .pb2_n(pb2), .flt1_n(f1), .flt2_n(f2));
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                end_of_test();
            end
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic t_mode(input logic [3:0] m);
        logic s1, s2;
        s1 = (m == `HPS_MODE_NOGLUE) || (m == `HPS_MODE_SINGLE) || (m == `HPS_MODE_DUAL);
        s2 = (m == `HPS_MODE_DUAL);
        alt_irq <= {~s2, ~s1};
        strap <= m;
        power_good <= 0;
        grant_n <= 0;
        card2 <= 2'b01;
        w(4);
        power_good <= 1;
        w(4);
        strap <= ~m;
        w(4);
        apb(0, `HPS_OFF_STATUS, 0);
        `CHK(q[3:0], m, "latched mode")
        apb(1, `HPS_OFF_CTRL, 32'h7);
        w(2);
        `CHK({pw1, l1, r1}, {s1, ~s1, ~s1}, "slot 1 unreleased")
        `CHK({pw2, l2, r2}, {s2, ~s2, ~s2}, "slot 2 unreleased")
        apb(1, `HPS_OFF_CTRL, 32'h1f);
        w(2);
        `CHK({r1, r2}, 2'b11, "slot resets released")
        `CHK({g3, q4}, {s2, s2 | 1'b0}, "alternate pin roles")
        `CHK({i14, i13}, {s1, s2}, "alternate interrupt roles")
        apb(1, `HPS_OFF_CTRL, 0);
        $display("mode %h done", m);
    endtask
    task automatic t_presence;
        for (int c = 0; c < 4; c++) begin
            card1 <= c[1:0];
            card2 <= ~c[1:0];
            w(5);
            apb(0, `HPS_OFF_STATUS, 0);
            `CHK({q[4], q[6:5]}, {c != 3, c[1:0]}, "slot 1 card")
            `CHK({q[9], q[11:10]}, {c != 0, ~c[1:0]}, "slot 2 card")
        end
        $display("presence done");
    endtask
    task automatic t_fault(input int s);
        logic [31:0] fb;
        fb = (s == 1) ? 32'h8 : 32'h2;
        apb(1, `HPS_OFF_CTRL, 32'h1e);
        apb(1, `HPS_OFF_INT_MASK, fb);
        apb(1, `HPS_OFF_INT_STAT, 32'hf);
        if (s == 1) short2 <= 1; else short1 <= 1;
        w(6);
        `CHK(s == 1 ? pw2 : pw1, 1'b1, "fault ignored when disabled")
        `CHK(irq, 1'b0, "no event when disabled")
        apb(1, `HPS_OFF_CTRL, 32'h1f);
        w(5);
        `CHK(s == 1 ? {pw2, r2} : {pw1, r1}, 2'b00, "slot isolated on fault")
        `CHK(irq, 1'b1, "fault interrupt")
        apb(1, `HPS_OFF_INT_MASK, 0);
        w(2);
        `CHK(irq, 1'b0, "masked interrupt")
        short1 <= 0;
        short2 <= 0;
        apb(1, `HPS_OFF_CTRL, 32'h1);
        apb(1, `HPS_OFF_INT_STAT, 32'hf);
        apb(1, `HPS_OFF_INT_MASK, 32'hf);
        w(2);
        `CHK(irq, 1'b0, "events cleared")
        $display("fault slot %0d done", s + 1);
    endtask
    initial begin
        w(12);
        presetn <= 1;
        w(1);
        `CHK({pw1, pw2, l1, l2, r1, r2}, 6'b001111, "idle after reset")
        t_mode(4'h3);
        t_mode(`HPS_MODE_NOGLUE);
        t_mode(`HPS_MODE_SINGLE);
        t_mode(`HPS_MODE_DUAL);
        t_presence();
        card1 <= 2'b00;
        card2 <= 2'b00;
        t_fault(0);
        t_fault(1);
        apb(0, 12'h010, 0);
        `CHK({err, q}, {1'b1, 32'h0}, "unmapped read refused")
        end_of_test();
    end
endmodule // test_hps_top

// ==== rtl/hps_map.svh ====
// Constants of the parallel hot plug slot signal block: offsets, fields, resets.
// Assumes a 32-bit APB with byte addresses and one register per aligned word.
//
// Contract
// [RQ1] Dual mode decodes both slot-2 presence inputs
// [RQ2] Slot-1 power enable only in modes f, 9, a
// [RQ3] Slot-2 power enable only in dual mode
// [RQ4] Slot-1 fault, if enabled, resets and isolates slot
// [RQ5] Slot-2 fault, if enabled, resets and isolates slot
// [RQ6] Slot-1 power lamp active-low in modes f, 9, a
// [RQ7] Slot-2 power lamp active-low in dual mode only
// [RQ8] Slot-1 reset active-low in modes f, 9, a
// [RQ9] Slot-2 reset active-low in dual mode only
// [RQ10] Both slot-1 presence inputs decode card and power
// [RQ11] Mode straps latched on power-good rising edge
// [RQ12] Unselected slot pins take alternate roles only
`ifndef HPS_MAP_SVH
`define HPS_MAP_SVH

`define HPS_OFF_CTRL      12'h000
`define HPS_OFF_STATUS    12'h004
`define HPS_OFF_INT_STAT  12'h008
`define HPS_OFF_INT_MASK  12'h00c

`define HPS_MODE_NOGLUE   4'hf
`define HPS_MODE_SINGLE   4'h9
`define HPS_MODE_DUAL     4'ha
`define HPS_MODE_RST      4'h0

// Synchroniser reset: power-good and straps low, active-low pins at idle high,
// so the alternate request and interrupt roles show no false pulse after reset
`define HPS_SYNC_RST      11'h03f

// Control register fields
`define HPS_CTRL_FLT_EN   0
`define HPS_CTRL_PWR1     1
`define HPS_CTRL_PWR2     2
`define HPS_CTRL_REL1     3
`define HPS_CTRL_REL2     4
`define HPS_CTRL_RST      5'h00

// Status register fields
`define HPS_ST_MODE_LSB   0
`define HPS_ST_SLOT1_LSB  4
`define HPS_ST_SLOT2_LSB  9

// Event bits: presence change and fault, per slot
`define HPS_EV_PRES1      0
`define HPS_EV_FLT1       1
`define HPS_EV_PRES2      2
`define HPS_EV_FLT2       3
`define HPS_EV_RST        4'h0

`endif

// ==== rtl/hps_pkg.sv ====
// Types shared by the hot plug slot signal modules.
// Assumes hps_map.svh supplies all numeric constants.
package hps_pkg;
    typedef logic [3:0] hps_mode_t;
    typedef enum logic [1:0] {
        HPS_WAIT_PG = 2'b01,
        HPS_RUN     = 2'b10
    } hps_strap_e;
endpackage

// ==== rtl/hps_slot.sv ====
// Per-slot power, lamp, reset and presence logic.
// Assumes synchronised pin levels from the top; outputs are all registered.
`timescale 1ns/1ns
module hps_slot
    import hps_pkg::*;
(
    input  wire logic pclk,        // Block clock
    input  wire logic presetn,     // Async reset, active low
    hps_slot_if.slot  sif          // Top-side connection
);
    logic       faulted_ff;
    logic       nxt_faulted;
    logic       power_on_ff;
    logic       nxt_power_on;
    logic       reset_n_ff;
    logic       lamp_n_ff;
    logic       present_ff;
    logic [1:0] code_ff;
    logic       pres_evt_ff;
    logic       fault_evt_ff;
    logic       nxt_present;

    // Set wins: a fault still present while software drops the request stays latched
    assign nxt_faulted  = sif.active & sif.fault_en &
                          (~sif.fault_n | (faulted_ff & sif.pwr_req));  // RQ4 RQ5
    assign nxt_power_on = sif.active & sif.pwr_req & ~nxt_faulted;
    assign nxt_present  = sif.active & (sif.pres_n != 2'b11);           // RQ1 RQ10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faulted_ff   <= 1'b0;
            fault_evt_ff <= 1'b0;
        end else begin
            faulted_ff   <= nxt_faulted;
            fault_evt_ff <= nxt_faulted & ~faulted_ff;
        end
    end

    // Reset is held whenever a selected slot's power is off, so a faulting slot is isolated at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_ff <= 1'b0;
            lamp_n_ff   <= 1'b1;
            reset_n_ff  <= 1'b1;
        end else begin
            power_on_ff <= nxt_power_on;                                // RQ2 RQ3
            lamp_n_ff   <= ~nxt_power_on;                               // RQ6 RQ7
            reset_n_ff  <= ~sif.active | (nxt_power_on & sif.rst_rel);  // RQ8 RQ9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            present_ff  <= 1'b0;
            code_ff     <= 2'b11;
            pres_evt_ff <= 1'b0;
        end else begin
            present_ff  <= nxt_present;
            code_ff     <= sif.active ? sif.pres_n : 2'b11;              // RQ1 RQ10
            pres_evt_ff <= nxt_present ^ present_ff;
        end
    end

    assign sif.power_on  = power_on_ff;
    assign sif.lamp_n    = lamp_n_ff;
    assign sif.reset_n   = reset_n_ff;
    assign sif.faulted   = faulted_ff;
    assign sif.present   = present_ff;
    assign sif.pwr_code  = code_ff;
    assign sif.pres_evt  = pres_evt_ff;
    assign sif.fault_evt = fault_evt_ff;

    a_fault_isolate: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        (sif.active && sif.fault_en && !sif.fault_n) |=>
            (!power_on_ff && !reset_n_ff && faulted_ff))
        else $error("fault did not reset and isolate slot");

    a_presence_decode: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        sif.active |=> (present_ff == ($past(sif.pres_n) != 2'b11)))
        else $error("presence decode wrong");

endmodule // hps_slot

// ==== rtl/hps_slot_if.sv ====
// Connection between the block top and one slot's control logic.
// Assumes both ends run on pclk; pin inputs arrive already synchronised.
`timescale 1ns/1ns
interface hps_slot_if;
    logic       active;       // Latched mode selects this slot
    logic       fault_en;     // Fault handling enabled
    logic       pwr_req;      // Software power request
    logic       rst_rel;      // Software reset release
    logic [1:0] pres_n;       // Synchronised presence pair {b,a}
    logic       fault_n;      // Synchronised power fault
    logic       power_on;     // Power enable to controller
    logic       lamp_n;       // Green power lamp
    logic       reset_n;      // Slot bus reset
    logic       faulted;      // Fault latched
    logic       present;      // Card installed
    logic [1:0] pwr_code;     // Presence code of card
    logic       pres_evt;     // Presence changed, one cycle
    logic       fault_evt;    // Fault newly latched, one cycle
    modport top  (output active, fault_en, pwr_req, rst_rel, pres_n, fault_n,
                  input  power_on, lamp_n, reset_n, faulted, present, pwr_code,
                         pres_evt, fault_evt);
    modport slot (input  active, fault_en, pwr_req, rst_rel, pres_n, fault_n,
                  output power_on, lamp_n, reset_n, faulted, present, pwr_code,
                         pres_evt, fault_evt);
endinterface // hps_slot_if

// ==== rtl/hps_top.sv ====
// Parallel hot plug slot signal block with APB registers and one interrupt.
// Assumes pin inputs are asynchronous to pclk; the grant input comes from
// the bus arbiter on pclk. Shared pads are modelled as separate ports.
`timescale 1ns/1ns
`include "hps_map.svh"
module hps_top
    import hps_pkg::*;
(
    input  wire logic        pclk,                 // APB clock, 250 MHz
    input  wire logic        presetn,              // Async reset, active low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB write
    input  wire logic [11:0] paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error, unmapped address
    input  wire logic        power_good,           // Power supply stable
    input  wire logic [3:0]  hot_plug_mode_strap,  // Mode straps
    input  wire logic        slot1_presence_a_n,   // Slot-1 present pin a
    input  wire logic        slot1_presence_b_n,   // Slot-1 present pin b
    input  wire logic        slot2_presence_a_n,   // Slot-2 present pin a
    input  wire logic        slot2_presence_b_n,   // Slot-2 present pin b
    input  wire logic        slot1_power_fault_n,  // Slot-1 power fault
    input  wire logic        slot2_power_fault_n,  // Slot-2 power fault
    input  wire logic        arb_grant_3_in_n,     // Grant from arbiter
    output logic             slot1_power_on,       // Slot-1 power enable
    output logic             slot2_power_on,       // Slot-2 power enable
    output logic             slot1_power_lamp_n,   // Slot-1 green lamp
    output logic             slot2_power_lamp_n,   // Slot-2 green lamp
    output logic             slot1_reset_n,        // Slot-1 bus reset
    output logic             slot2_reset_n,        // Slot-2 bus reset
    output logic             bus_grant_3_n,        // Alternate grant pin role
    output logic             bus_request_4_n,      // Alternate request to arbiter
    output logic             slot_interrupt_14_n,  // Alternate interrupt role
    output logic             slot_interrupt_13_n,  // Alternate interrupt role
    output logic             irq                   // Interrupt, level
);
    localparam int NPIN = 11;
    localparam int P_PG = 10;
    localparam int P_S1A = 5;
    localparam int P_S1B = 4;
    localparam int P_S2A = 3;
    localparam int P_S2B = 2;
    localparam int P_F1 = 1;
    localparam int P_F2 = 0;

    function automatic logic slot1_mode(input hps_mode_t m);
        return (m == `HPS_MODE_NOGLUE) || (m == `HPS_MODE_SINGLE) ||
               (m == `HPS_MODE_DUAL);
    endfunction

    function automatic logic slot2_mode(input hps_mode_t m);
        return (m == `HPS_MODE_DUAL);
    endfunction

    logic [NPIN-1:0] meta_ff;
    logic [NPIN-1:0] sync_ff;
    logic            pg_q_ff;
    logic            pg_rise;
    hps_strap_e      strap_st_ff;
    hps_strap_e      nxt_strap_st;
    hps_mode_t       mode_ff;
    logic [4:0]      ctrl_ff;
    logic [3:0]      int_stat_ff;
    logic [3:0]      int_mask_ff;
    logic [3:0]      events;
    logic            irq_ff;
    logic [31:0]     prdata_ff;
    logic            pready_ff;
    logic            pslverr_ff;
    logic            wr_en;
    logic            slot1_on;
    logic            slot2_on;
    logic            alt_gnt_ff;
    logic            alt_req_ff;
    logic            alt_irq14_ff;
    logic            alt_irq13_ff;
    logic [31:0]     status_word;
    logic            mapped;

    hps_slot_if sif [2] ();

    // Every pin but the arbiter grant passes two flops; only sync_ff is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= `HPS_SYNC_RST;
            sync_ff <= `HPS_SYNC_RST;
        end else begin
            meta_ff <= {power_good, hot_plug_mode_strap, slot1_presence_a_n,
                        slot1_presence_b_n, slot2_presence_a_n, slot2_presence_b_n,
                        slot1_power_fault_n, slot2_power_fault_n};
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_q_ff <= 1'b0;
        end else begin
            pg_q_ff <= sync_ff[P_PG];
        end
    end

    assign pg_rise = sync_ff[P_PG] & ~pg_q_ff;

    // Strap capture: while power-good is low the slots stay unselected
    always_comb begin
        nxt_strap_st = strap_st_ff;
        unique case (strap_st_ff)
            HPS_WAIT_PG: if (pg_rise) nxt_strap_st = HPS_RUN;
            HPS_RUN:     if (!sync_ff[P_PG]) nxt_strap_st = HPS_WAIT_PG;
            default:     nxt_strap_st = HPS_WAIT_PG;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_st_ff <= HPS_WAIT_PG;
            mode_ff     <= `HPS_MODE_RST;
        end else begin
            strap_st_ff <= nxt_strap_st;
            if (strap_st_ff == HPS_WAIT_PG && pg_rise) begin
                mode_ff <= sync_ff[P_F2+9:P_F2+6];                       // RQ11
            end else if (!sync_ff[P_PG]) begin
                mode_ff <= `HPS_MODE_RST;
            end
        end
    end

    // Slot selection from the latched mode
    assign slot1_on = (strap_st_ff == HPS_RUN) & slot1_mode(mode_ff);   // RQ2 RQ6 RQ8
    assign slot2_on = (strap_st_ff == HPS_RUN) & slot2_mode(mode_ff);   // RQ3 RQ7 RQ9

    assign sif[0].active   = slot1_on;
    assign sif[0].pres_n   = {sync_ff[P_S1B], sync_ff[P_S1A]};           // RQ10
    assign sif[0].fault_n  = sync_ff[P_F1];
    assign sif[0].pwr_req  = ctrl_ff[`HPS_CTRL_PWR1];
    assign sif[0].rst_rel  = ctrl_ff[`HPS_CTRL_REL1];
    assign sif[1].active   = slot2_on;
    assign sif[1].pres_n   = {sync_ff[P_S2B], sync_ff[P_S2A]};           // RQ1
    assign sif[1].fault_n  = sync_ff[P_F2];
    assign sif[1].pwr_req  = ctrl_ff[`HPS_CTRL_PWR2];
    assign sif[1].rst_rel  = ctrl_ff[`HPS_CTRL_REL2];

    for (genvar i = 0; i < 2; i++) begin : g_slot
        assign sif[i].fault_en = ctrl_ff[`HPS_CTRL_FLT_EN];
        hps_slot u_slot (
            .pclk    (pclk),
            .presetn (presetn),
            .sif     (sif[i])
        );
    end

    assign slot1_power_on     = sif[0].power_on;
    assign slot2_power_on     = sif[1].power_on;
    assign slot1_power_lamp_n = sif[0].lamp_n;
    assign slot2_power_lamp_n = sif[1].lamp_n;
    assign slot1_reset_n      = sif[0].reset_n;
    assign slot2_reset_n      = sif[1].reset_n;

    // Alternate roles are idle-high while the pins serve hot plug
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_gnt_ff   <= 1'b1;
            alt_req_ff   <= 1'b1;
            alt_irq14_ff <= 1'b1;
            alt_irq13_ff <= 1'b1;
        end else begin
            alt_gnt_ff   <= slot2_on | arb_grant_3_in_n;                  // RQ12
            alt_req_ff   <= slot2_on | sync_ff[P_S2B];                    // RQ12
            alt_irq14_ff <= slot1_on | sync_ff[P_F1];                     // RQ12
            alt_irq13_ff <= slot2_on | sync_ff[P_F2];                     // RQ12
        end
    end

    assign bus_grant_3_n       = alt_gnt_ff;
    assign bus_request_4_n     = alt_req_ff;
    assign slot_interrupt_14_n = alt_irq14_ff;
    assign slot_interrupt_13_n = alt_irq13_ff;

    // APB slave: zero wait states, data prepared in the setup cycle
    assign wr_en  = psel & penable & pready_ff & pwrite;
    assign mapped = (paddr == `HPS_OFF_CTRL) || (paddr == `HPS_OFF_STATUS) ||
                    (paddr == `HPS_OFF_INT_STAT) || (paddr == `HPS_OFF_INT_MASK);

    always_comb begin
        status_word = '0;
        status_word[`HPS_ST_MODE_LSB +: 4]  = mode_ff;
        status_word[`HPS_ST_SLOT1_LSB +: 5] = {sif[0].power_on, sif[0].faulted,
                                               sif[0].pwr_code, sif[0].present};
        status_word[`HPS_ST_SLOT2_LSB +: 5] = {sif[1].power_on, sif[1].faulted,
                                               sif[1].pwr_code, sif[1].present};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~mapped;
            if (psel && !penable) begin
                unique case (paddr)
                    `HPS_OFF_CTRL:     prdata_ff <= {27'h0, ctrl_ff};
                    `HPS_OFF_STATUS:   prdata_ff <= status_word;
                    `HPS_OFF_INT_STAT: prdata_ff <= {28'h0, int_stat_ff};
                    `HPS_OFF_INT_MASK: prdata_ff <= {28'h0, int_mask_ff};
                    default:           prdata_ff <= '0;
                endcase
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `HPS_CTRL_RST;
        end else if (wr_en && paddr == `HPS_OFF_CTRL) begin
            ctrl_ff <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_ff <= `HPS_EV_RST;
        end else if (wr_en && paddr == `HPS_OFF_INT_MASK) begin
            int_mask_ff <= pwdata[3:0];
        end
    end

    assign events[`HPS_EV_PRES1] = sif[0].pres_evt;
    assign events[`HPS_EV_FLT1]  = sif[0].fault_evt;
    assign events[`HPS_EV_PRES2] = sif[1].pres_evt;
    assign events[`HPS_EV_FLT2]  = sif[1].fault_evt;

    // Write one to clear; a new event in the same cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= `HPS_EV_RST;
        end else if (wr_en && paddr == `HPS_OFF_INT_STAT) begin
            int_stat_ff <= (int_stat_ff & ~pwdata[3:0]) | events;
        end else begin
            int_stat_ff <= int_stat_ff | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |((int_stat_ff | events) & int_mask_ff);
        end
    end

    assign irq = irq_ff;

    a_mode_latch: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (strap_st_ff == HPS_WAIT_PG && pg_rise) |=>
            (mode_ff == $past(sync_ff[9:6]) && strap_st_ff == HPS_RUN))
        else $error("mode not latched on power-good rise");

    a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        (strap_st_ff == HPS_RUN && sync_ff[P_PG] && !pg_rise) |=>
            $stable(mode_ff))
        else $error("mode changed while running");

    a_pwr1_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        !slot1_on |=> !slot1_power_on)
        else $error("slot-1 power on outside its modes");

    a_pwr2_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        !slot2_on |=> !slot2_power_on)
        else $error("slot-2 power on outside dual mode");

    a_lamp1_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        ##1 (slot1_power_lamp_n == !slot1_power_on))
        else $error("slot-1 lamp does not follow power");

    a_lamp2_dual: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        !slot2_on |=> slot2_power_lamp_n)
        else $error("slot-2 lamp lit outside dual mode");

    a_rst1_power: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (slot1_on && !sif[0].pwr_req) |=> !slot1_reset_n)
        else $error("slot-1 reset released while unpowered");

    a_rst2_fault: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        (slot2_on && ctrl_ff[`HPS_CTRL_FLT_EN] && !sync_ff[P_F2]) |=>
            (!slot2_reset_n && !slot2_power_on))
        else $error("slot-2 fault did not isolate slot");

    a_rst2_idle: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        !slot2_on |=> slot2_reset_n)
        else $error("slot-2 reset driven outside dual mode");

    a_alt_route: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        !slot2_on |=> (bus_request_4_n == $past(sync_ff[P_S2B])))
        else $error("request pin not routed to alternate role");

endmodule // hps_top
